// ---- logic/pms_gate.sv ----
/*
  Clock gate sequencer: registered enable that breaks for a fixed gap on
  every source change so no partial pulse reaches the gated domain.
  Assumes the downstream cell latches the enable while its clock is low.
*/
`timescale 1ns/1ps
`default_nettype none

module pms_gate #(
  parameter int GAP = pms_pkg::PMS_GATE_GAP_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  pms_gate_if.gate g
);

  logic [3:0] cnt_reg;

  // --------------------------------------------------------------------
  // Enable sequencing
  // --------------------------------------------------------------------
  // Break-before-make: the enable is held low while the mux changes over
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= 4'h0;
      g.en <= 1'b1;
    end else if (g.sw) begin
      cnt_reg <= 4'(GAP);
      g.en <= 1'b0;
    end else if (cnt_reg > 4'h1) begin
      cnt_reg <= cnt_reg - 4'h1;
      g.en <= 1'b0;
    end else begin
      cnt_reg <= 4'h0;
      g.en <= g.want;
    end
  end

endmodule

`default_nettype wire

// ---- logic/pms_gate_if.sv ----
/*
  Carrier between the mode logic and one clock gate sequencer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface pms_gate_if;
  logic want; // Gate should be open after this edge
  logic sw; // Source changes at this edge
  logic en; // Registered gate enable
  modport ctrl (output want, output sw, input en);
  modport gate (input want, input sw, output en);
endinterface

`default_nettype wire

// ---- logic/pms_pkg.sv ----
/*
  Shared constants and types of the power mode selector: mode codes, clock
  source codes and the timing count of the clock gate break.
  Assumes one system clock and a synchronous active-low reset.
*/
`default_nettype none

package pms_pkg;

  // ----------------------------------------------------------------------
  // Mode codes, one-hot; idle code is the run code shifted up by three
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    PMS_PRIMARY_RUN_MODE = 7'h01,
    PMS_SECONDARY_RUN_MODE = 7'h02,
    PMS_INTERNAL_RUN_MODE = 7'h04,
    PMS_PRIMARY_IDLE_MODE = 7'h08,
    PMS_SECONDARY_IDLE_MODE = 7'h10,
    PMS_INTERNAL_IDLE_MODE = 7'h20,
    PMS_SLEEP_MODE = 7'h40
  } pms_mode_type;

  localparam logic [6:0] PMS_RUN_MASK = 7'h07;
  localparam logic [6:0] PMS_IDLE_MASK = 7'h38;
  localparam int PMS_IDLE_SHIFT = 3;

  // ----------------------------------------------------------------------
  // Clock source select codes and active source codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] PMS_CSS_PRIMARY = 2'h0;
  localparam logic [1:0] PMS_CSS_SECONDARY = 2'h1;
  localparam int PMS_CSS_INTERNAL_BIT = 1;
  localparam logic [1:0] PMS_SRC_PRIMARY = 2'h0;
  localparam logic [1:0] PMS_SRC_SECONDARY = 2'h1;
  localparam logic [1:0] PMS_SRC_INTERNAL = 2'h2;
  localparam logic [1:0] PMS_SRC_NONE = 2'h3;

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam int PMS_GATE_GAP_CYCLES = 1;
  localparam logic [3:0] PMS_OSC_CONFIG_RESET = 4'h0;

endpackage

`default_nettype wire

// ---- logic/pms_top.sv ----
/*
  Power mode selector: holds the current power mode, switches the clock
  source, sequences the CPU and peripheral clock gates and the oscillator
  enables. Assumes the core gives a one-cycle pulse per sleep instruction
  and the oscillators report ready as levels synchronous to CLK_SYS_I.
*/
`timescale 1ns/1ps
`default_nettype none

module pms_top (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic [1:0] CLOCK_SOURCE_SELECT_I,
  input wire logic CPU_HALT_SELECT_I,
  input wire logic SLEEP_EXEC_I,
  input wire logic WAKE_INTERRUPT_I,
  input wire logic WAKE_WDT_I,
  input wire logic [3:0] PRIMARY_OSC_CONFIG_I,
  input wire logic PRIMARY_OSC_READY_I,
  input wire logic SECONDARY_OSC_ENABLE_I,
  input wire logic SECONDARY_OSC_READY_I,
  input wire logic INTERNAL_FAST_SELECT_I,
  input wire logic INTERNAL_OSC_READY_I,
  output logic [6:0] MODE_O,
  output logic [1:0] CLK_SOURCE_O,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic PRIMARY_OSC_EN_O,
  output logic [3:0] PRIMARY_OSC_CONFIG_O,
  output logic FAST_INTERNAL_OSC_EN_O,
  output logic SLOW_INTERNAL_OSC_EN_O,
  output logic PRIMARY_CLOCK_ACTIVE_FLAG_O,
  output logic SECONDARY_CLOCK_ACTIVE_O
);

  pms_pkg::pms_mode_type mode_reg;
  pms_pkg::pms_mode_type mode_next;
  pms_pkg::pms_mode_type run_target;
  logic [1:0] src_reg;
  logic [1:0] src_next;
  logic wake_pend_reg;
  logic css_ready;
  logic wake;
  logic is_run;
  logic is_idle;
  logic want_pri;
  logic want_int;
  pms_gate_if cpu_g();
  pms_gate_if per_g();

  // --------------------------------------------------------------------
  // Source decoding
  // --------------------------------------------------------------------
  // Run mode named by the select field, and whether its source runs
  function automatic pms_pkg::pms_mode_type css_run(input logic [1:0] css);
    if (css[pms_pkg::PMS_CSS_INTERNAL_BIT])
      return pms_pkg::PMS_INTERNAL_RUN_MODE;
    else if (css == pms_pkg::PMS_CSS_SECONDARY)
      return pms_pkg::PMS_SECONDARY_RUN_MODE;
    else
      return pms_pkg::PMS_PRIMARY_RUN_MODE;
  endfunction

  function automatic logic [1:0] src_of(input pms_pkg::pms_mode_type m);
    case (m)
      pms_pkg::PMS_PRIMARY_RUN_MODE, pms_pkg::PMS_PRIMARY_IDLE_MODE:
        return pms_pkg::PMS_SRC_PRIMARY;
      pms_pkg::PMS_SECONDARY_RUN_MODE, pms_pkg::PMS_SECONDARY_IDLE_MODE:
        return pms_pkg::PMS_SRC_SECONDARY;
      pms_pkg::PMS_INTERNAL_RUN_MODE, pms_pkg::PMS_INTERNAL_IDLE_MODE:
        return pms_pkg::PMS_SRC_INTERNAL;
      default:
        return pms_pkg::PMS_SRC_NONE;
    endcase
  endfunction

  // Secondary counts as running only with its enable set as well
  always_comb begin
    if (CLOCK_SOURCE_SELECT_I[pms_pkg::PMS_CSS_INTERNAL_BIT])
      css_ready = INTERNAL_OSC_READY_I;
    else if (CLOCK_SOURCE_SELECT_I == pms_pkg::PMS_CSS_SECONDARY)
      css_ready = SECONDARY_OSC_ENABLE_I && SECONDARY_OSC_READY_I;
    else
      css_ready = PRIMARY_OSC_READY_I;
  end

  assign wake = WAKE_INTERRUPT_I || WAKE_WDT_I;
  assign is_run = |(mode_reg & pms_pkg::PMS_RUN_MASK);
  assign is_idle = |(mode_reg & pms_pkg::PMS_IDLE_MASK);

  // --------------------------------------------------------------------
  // Mode transitions
  // --------------------------------------------------------------------
  // A run mode follows the select field only once the new source runs;
  // otherwise the previous run mode stays and its idle twin is used
  always_comb begin
    run_target = css_ready ? css_run(CLOCK_SOURCE_SELECT_I) : mode_reg;
    mode_next = mode_reg;
    case (mode_reg)
      pms_pkg::PMS_PRIMARY_RUN_MODE, pms_pkg::PMS_SECONDARY_RUN_MODE,
      pms_pkg::PMS_INTERNAL_RUN_MODE: begin
        if (SLEEP_EXEC_I) begin
          if (CPU_HALT_SELECT_I)
            mode_next = pms_pkg::pms_mode_type'(run_target << pms_pkg::PMS_IDLE_SHIFT);
          else
            mode_next = pms_pkg::PMS_SLEEP_MODE;
        end else begin
          mode_next = run_target;
        end
      end
      pms_pkg::PMS_PRIMARY_IDLE_MODE, pms_pkg::PMS_SECONDARY_IDLE_MODE,
      pms_pkg::PMS_INTERNAL_IDLE_MODE: begin
        // Select fields are not touched; the same source resumes
        if (wake)
          mode_next = pms_pkg::pms_mode_type'(mode_reg >> pms_pkg::PMS_IDLE_SHIFT);
      end
      pms_pkg::PMS_SLEEP_MODE: begin
        // No clock reaches the core until the selected source is ready
        if ((wake || wake_pend_reg) && css_ready)
          mode_next = css_run(CLOCK_SOURCE_SELECT_I);
      end
      default: mode_next = pms_pkg::PMS_PRIMARY_RUN_MODE;
    endcase
    src_next = src_of(mode_next);
  end

  // Mode and source registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      mode_reg <= pms_pkg::PMS_PRIMARY_RUN_MODE;
      src_reg <= pms_pkg::PMS_SRC_PRIMARY;
    end else begin
      mode_reg <= mode_next;
      src_reg <= src_next;
    end
  end

  // Wake seen while the source is still starting is remembered
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I)
      wake_pend_reg <= 1'b0;
    else if (mode_reg == pms_pkg::PMS_SLEEP_MODE && mode_next == mode_reg)
      wake_pend_reg <= wake_pend_reg || wake;
    else
      wake_pend_reg <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Clock gates
  // --------------------------------------------------------------------
  // Gates follow the next mode so they line up with the mode register
  assign cpu_g.want = |(mode_next & pms_pkg::PMS_RUN_MASK);
  assign per_g.want = mode_next != pms_pkg::PMS_SLEEP_MODE;
  assign cpu_g.sw = (src_next != src_reg) && (src_next != pms_pkg::PMS_SRC_NONE)
                    && (src_reg != pms_pkg::PMS_SRC_NONE);
  assign per_g.sw = cpu_g.sw;

  pms_gate #(.GAP(pms_pkg::PMS_GATE_GAP_CYCLES)) u_cpu_gate (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .g(cpu_g.gate)
  );

  pms_gate #(.GAP(pms_pkg::PMS_GATE_GAP_CYCLES)) u_per_gate (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .g(per_g.gate)
  );

  assign CPU_CLK_EN_O = cpu_g.en;
  assign PERIPH_CLK_EN_O = per_g.en;
  assign MODE_O = mode_reg;
  assign CLK_SOURCE_O = src_reg;

  // --------------------------------------------------------------------
  // Oscillator enables and status flags
  // --------------------------------------------------------------------
  // A requested source is started early so a pending switch can finish
  assign want_pri = (src_next == pms_pkg::PMS_SRC_PRIMARY) || (is_run && !SLEEP_EXEC_I
                    && CLOCK_SOURCE_SELECT_I == pms_pkg::PMS_CSS_PRIMARY);
  // A wake in sleep must restart the internal block too, or it never comes ready
  assign want_int = (src_next == pms_pkg::PMS_SRC_INTERNAL) || (is_run && !SLEEP_EXEC_I
                    && CLOCK_SOURCE_SELECT_I[pms_pkg::PMS_CSS_INTERNAL_BIT])
                    || (mode_reg == pms_pkg::PMS_SLEEP_MODE && wake_pend_reg
                    && CLOCK_SOURCE_SELECT_I[pms_pkg::PMS_CSS_INTERNAL_BIT]);

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      PRIMARY_OSC_EN_O <= 1'b1;
      FAST_INTERNAL_OSC_EN_O <= 1'b0;
      SLOW_INTERNAL_OSC_EN_O <= 1'b0;
      PRIMARY_CLOCK_ACTIVE_FLAG_O <= 1'b0;
      SECONDARY_CLOCK_ACTIVE_O <= 1'b0;
    end else begin
      // Sleep drops every enable and flag; wake in sleep restarts one
      PRIMARY_OSC_EN_O <= want_pri || (mode_reg == pms_pkg::PMS_SLEEP_MODE && wake_pend_reg
                          && CLOCK_SOURCE_SELECT_I == pms_pkg::PMS_CSS_PRIMARY);
      FAST_INTERNAL_OSC_EN_O <= want_int && INTERNAL_FAST_SELECT_I;
      SLOW_INTERNAL_OSC_EN_O <= want_int && !INTERNAL_FAST_SELECT_I;
      PRIMARY_CLOCK_ACTIVE_FLAG_O <= src_next == pms_pkg::PMS_SRC_PRIMARY
                                     && PRIMARY_OSC_READY_I;
      SECONDARY_CLOCK_ACTIVE_O <= src_next == pms_pkg::PMS_SRC_SECONDARY;
    end
  end

  // Oscillator type is caught while reset is held and kept afterwards
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I)
      PRIMARY_OSC_CONFIG_O <= PRIMARY_OSC_CONFIG_I;
    else
      PRIMARY_OSC_CONFIG_O <= PRIMARY_OSC_CONFIG_O;
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  sleep_entry_a: assert property (is_run && SLEEP_EXEC_I && !CPU_HALT_SELECT_I
    |=> MODE_O == pms_pkg::PMS_SLEEP_MODE ##0 !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
    else $error("sleep not entered with clocks stopped");
  idle_entry_a: assert property (is_run && SLEEP_EXEC_I && CPU_HALT_SELECT_I
    |=> is_idle && !CPU_CLK_EN_O)
    else $error("idle not entered with cpu stopped");
  sleep_quiet_a: assert property (mode_reg == pms_pkg::PMS_SLEEP_MODE
    |-> !PRIMARY_CLOCK_ACTIVE_FLAG_O && !SECONDARY_CLOCK_ACTIVE_O && !PERIPH_CLK_EN_O
        && !CPU_CLK_EN_O && (wake_pend_reg || !PRIMARY_OSC_EN_O
        && !FAST_INTERNAL_OSC_EN_O && !SLOW_INTERNAL_OSC_EN_O))
    else $error("status or clock live in sleep");
  idle_wake_a: assert property (is_idle && wake
    |=> MODE_O == ($past(MODE_O) >> pms_pkg::PMS_IDLE_SHIFT))
    else $error("idle wake to wrong run mode");
  idle_hold_a: assert property (is_idle && !wake |=> $stable(MODE_O))
    else $error("idle left without wake");
  sec_defer_a: assert property (is_run && !SLEEP_EXEC_I && !SECONDARY_OSC_ENABLE_I
    && CLOCK_SOURCE_SELECT_I == pms_pkg::PMS_CSS_SECONDARY
    && mode_reg != pms_pkg::PMS_SECONDARY_RUN_MODE
    |=> MODE_O != pms_pkg::PMS_SECONDARY_RUN_MODE)
    else $error("secondary run entered without enable");
  int_switch_a: assert property (is_run && !SLEEP_EXEC_I && INTERNAL_OSC_READY_I
    && CLOCK_SOURCE_SELECT_I[pms_pkg::PMS_CSS_INTERNAL_BIT]
    |=> MODE_O == pms_pkg::PMS_INTERNAL_RUN_MODE ##0 CLK_SOURCE_O == pms_pkg::PMS_SRC_INTERNAL)
    else $error("internal switch missed");
  run_clocks_a: assert property (is_run && $past(is_run) && $stable(MODE_O)
    |-> CPU_CLK_EN_O && PERIPH_CLK_EN_O)
    else $error("run mode without clocks");
  reset_mode_a: assert property (@(posedge CLK_SYS_I) disable iff (1'b0) !NRST_I
    |=> MODE_O == pms_pkg::PMS_PRIMARY_RUN_MODE)
    else $error("reset mode not primary run");

  sleep_wake_c: cover property (mode_reg == pms_pkg::PMS_SLEEP_MODE ##1 is_run);
  idle_wake_c: cover property (is_idle && wake);
  secondary_run_mode_c: cover property (MODE_O == pms_pkg::PMS_SECONDARY_RUN_MODE);

endmodule

`default_nettype wire

// ---- verification/pms_osc_model.sv ----
/*
  Oscillator sources seen from the mode selector: each one reports ready a
  fixed warm-up after its enable rises and drops ready at once when disabled.
  Assumes enables change only on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pms_osc_model #(
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic pri_en_i,
  input wire logic sec_en_i,
  input wire logic int_en_i,
  output logic pri_rdy_o,
  output logic sec_rdy_o,
  output logic int_rdy_o
);
  int pc = 0;
  int sc = 0;
  int ic = 0;
  // Warm-up counters; a slow DLY makes the selector wait on every switch to a source whose enable was low
  always_ff @(posedge clk_i) begin
    pc <= pri_en_i ? ((pc < DLY) ? pc + 1 : pc) : 0;
    sc <= sec_en_i ? ((sc < DLY) ? sc + 1 : sc) : 0;
    ic <= int_en_i ? ((ic < DLY) ? ic + 1 : ic) : 0;
  end
  // Ready falls with the enable, so a stopped source never looks alive
  assign pri_rdy_o = pri_en_i && (pc >= DLY);
  assign sec_rdy_o = sec_en_i && (sc >= DLY);
  assign int_rdy_o = int_en_i && (ic >= DLY);
endmodule

`default_nettype wire

// ---- verification/power_mode_selector_test.sv ----
/*
  Self-checking bench of the power mode selector: a table of run, idle and
  sleep cases, then reset and refusal cases.
  Assumes pms_top and the oscillator model; one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module power_mode_selector_test;
  typedef struct {
    logic [1:0] sel;
    logic halt;
    logic [6:0] run;
    logic [6:0] low;
    logic [1:0] src;
  } pms_row_type;
  logic clk, rst_n, halt, slp, wk_i, wk_w, p_rdy, s_en, s_rdy, fast, i_rdy;
  logic [1:0] sel, src;
  logic [3:0] cfg, cfg_o;
  logic [6:0] mode;
  logic cpu, per, p_en, f_en, l_en, p_act, s_act;
  int num_errors = 0;
  int checks_done = 0;
  pms_row_type rows [7];

  pms_top pms_top_inst (.CLK_SYS_I(clk), .NRST_I(rst_n), .CLOCK_SOURCE_SELECT_I(sel),
    .CPU_HALT_SELECT_I(halt), .SLEEP_EXEC_I(slp), .WAKE_INTERRUPT_I(wk_i),
    .WAKE_WDT_I(wk_w), .PRIMARY_OSC_CONFIG_I(cfg), .PRIMARY_OSC_READY_I(p_rdy),
    .SECONDARY_OSC_ENABLE_I(s_en), .SECONDARY_OSC_READY_I(s_rdy),
    .INTERNAL_FAST_SELECT_I(fast), .INTERNAL_OSC_READY_I(i_rdy), .MODE_O(mode),
    .CLK_SOURCE_O(src), .CPU_CLK_EN_O(cpu), .PERIPH_CLK_EN_O(per), .PRIMARY_OSC_EN_O(p_en),
    .PRIMARY_OSC_CONFIG_O(cfg_o), .FAST_INTERNAL_OSC_EN_O(f_en),
    .SLOW_INTERNAL_OSC_EN_O(l_en), .PRIMARY_CLOCK_ACTIVE_FLAG_O(p_act),
    .SECONDARY_CLOCK_ACTIVE_O(s_act));

  pms_osc_model #(.DLY(3)) pms_osc_model_inst (.clk_i(clk), .pri_en_i(p_en), .sec_en_i(s_en),
    .int_en_i(f_en | l_en), .pri_rdy_o(p_rdy), .sec_rdy_o(s_rdy), .int_rdy_o(i_rdy));

  // Free-running 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Inputs move 2 ns after the edge, outputs are settled by then
  task automatic tick();
    @(posedge clk);
    #2;
  endtask

  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait: a source that never comes ready ends in a mismatch
  task automatic wait_mode(input logic [6:0] m);
    for (int n = 0; n < 40 && mode !== m; n++) tick();
    chk(mode, m);
  endtask

  // One sleep instruction, one cycle long; the core has no other way in
  task automatic sleep_pulse(input logic h);
    halt = h;
    slp = 1'b1;
    tick();
    slp = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog far beyond the 115 or so cycles the run needs
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    rows[0] = '{2'h0, 1'b1, 7'h01, 7'h08, 2'h0};
    rows[1] = '{2'h1, 1'b1, 7'h02, 7'h10, 2'h1};
    rows[2] = '{2'h2, 1'b1, 7'h04, 7'h20, 2'h2};
    rows[3] = '{2'h3, 1'b0, 7'h04, 7'h40, 2'h2};
    rows[4] = '{2'h0, 1'b0, 7'h01, 7'h40, 2'h0};
    rows[5] = '{2'h1, 1'b0, 7'h02, 7'h40, 2'h1};
    rows[6] = '{2'h3, 1'b1, 7'h04, 7'h20, 2'h2};
    {rst_n, halt, slp, wk_i, wk_w, fast} = '0;
    sel = 2'h0;
    s_en = 1'b1;
    cfg = 4'h5;
    repeat (10) tick();
    chk(mode, 7'h01);
    chk({3'h0, cfg_o}, 7'h05);
    rst_n = 1'b1;
    // Table: enter run by select, then idle or sleep, then wake
    for (int i = 0; i < 7; i++) begin
      fast = i[0];
      sel = rows[i].sel;
      wait_mode(rows[i].run);
      repeat (2) tick();
      chk({5'h0, cpu, per}, 7'h03);
      chk({5'h0, src}, {5'h0, rows[i].src});
      chk({5'h0, p_act, s_act}, {5'h0, rows[i].src == 2'h0, rows[i].src == 2'h1});
      chk({6'h0, p_en}, {6'h0, rows[i].src == 2'h0});
      if (rows[i].sel[1]) chk({5'h0, f_en, l_en}, {5'h0, fast, ~fast});
      sleep_pulse(rows[i].halt);
      chk(mode, rows[i].low);
      halt = ~rows[i].halt;
      sel = ~rows[i].sel;
      repeat (3) tick();
      chk(mode, rows[i].low);
      chk({5'h0, cpu, per}, {5'h0, 1'b0, rows[i].halt});
      if (!rows[i].halt) chk({src, p_act, s_act, p_en, f_en, l_en}, 7'h60);
      sel = rows[i].sel;
      if (i[0]) wk_w = 1'b1;
      else wk_i = 1'b1;
      tick();
      {wk_i, wk_w} = 2'h0;
      wait_mode(rows[i].run);
    end
    // Secondary select while its enable is clear must wait
    sel = 2'h0;
    wait_mode(7'h01);
    s_en = 1'b0;
    sel = 2'h1;
    repeat (10) tick();
    chk(mode, 7'h01);
    // Idle entry with the secondary not ready keeps the current source
    sleep_pulse(1'b1);
    chk(mode, 7'h08);
    wk_i = 1'b1;
    tick();
    wk_i = 1'b0;
    wait_mode(7'h01);
    s_en = 1'b1;
    wait_mode(7'h02);
    // A sleep instruction while idle is ignored
    sleep_pulse(1'b1);
    chk(mode, 7'h10);
    sleep_pulse(1'b0);
    tick();
    chk(mode, 7'h10);
    wk_i = 1'b1;
    tick();
    wk_i = 1'b0;
    wait_mode(7'h02);
    // Reset in mid-run recaptures the config and returns to primary run
    rst_n = 1'b0;
    cfg = 4'ha;
    repeat (2) tick();
    chk(mode, 7'h01);
    chk({3'h0, cfg_o}, 7'h0a);
    chk({5'h0, cpu, per}, 7'h03);
    rst_n = 1'b1;
    repeat (2) tick();
    report_and_stop();
  end
endmodule

`default_nettype wire
